// File: uart_irq_fifo_pkg.sv
// package for the uart channel interrupt and fifo control block
// assumes one clock domain; all event inputs come from logic on that clock
package uart_irq_fifo_pkg;

   // ***********************************************************
   // register map (byte addresses on apb)
   // ***********************************************************
   localparam logic [7:0] ADDR_INTERRUPT_ENABLE = 8'h00;
   localparam logic [7:0] ADDR_INTERRUPT_STATUS = 8'h04;
   localparam logic [7:0] ADDR_FIFO_CONTROL = 8'h08;
   localparam logic [7:0] ADDR_ENHANCED_FUNCTION = 8'h0C;
   localparam logic [7:0] ADDR_FEATURE_CONTROL = 8'h10;
   localparam logic [7:0] ADDR_PROGRAMMABLE_TRIGGER = 8'h14;

   localparam logic [7:0] RESET_BYTE = 8'h00;
   localparam logic [7:0] LEVEL_ZERO = 8'h00;
   localparam logic [7:0] FIFO_DEPTH = 8'h80;

   // ***********************************************************
   // field positions
   // ***********************************************************
   localparam int IE_RX_DATA = 0;
   localparam int IE_TX_READY = 1;
   localparam int IE_LINE = 2;
   localparam int IE_MODEM = 3;
   localparam int IE_XOFF = 5;
   localparam int IE_RTS = 6;
   localparam int IE_CTS = 7;
   localparam int EF_ENHANCED = 4;
   localparam int EF_AUTO_RTS = 6;
   localparam int EF_AUTO_CTS = 7;
   localparam int FC_ENABLE = 0;
   localparam int FC_RX_FLUSH = 1;
   localparam int FC_TX_FLUSH = 2;
   localparam int FC_DMA = 3;
   localparam int FT_RS485 = 3;
   localparam int FT_TRG_TARGET = 7;
   localparam logic [7:0] IE_UPPER_MASK = 8'hF0;

   // ***********************************************************
   // interrupt codes, bits 5..0 of interrupt_status
   // ***********************************************************
   typedef enum logic [5:0] {
      CODE_LINE = 6'h06,
      CODE_TIMEOUT = 6'h0C,
      CODE_RX_DATA = 6'h04,
      CODE_TX_READY = 6'h02,
      CODE_MODEM = 6'h00,
      CODE_XOFF = 6'h10,
      CODE_FLOW = 6'h20,
      CODE_NONE = 6'h01
   } irq_code_e;

   // ***********************************************************
   // timing: receive time-out is four characters plus twelve bits
   // ***********************************************************
   localparam logic [7:0] TIMEOUT_CHARS = 8'h04;
   localparam logic [7:0] TIMEOUT_EXTRA_BITS = 8'h0C;

   localparam logic [1:0] TABLE_PROG = 2'h3;

   // events from the receive and modem logic, one-cycle pulses
   typedef struct packed {
      logic char_in;
      logic [3:0] line_err;
      logic xoff_match;
      logic xon_match;
      logic special_match;
   } rx_event_s;

   typedef struct packed {
      logic [3:0] msr_delta;
      logic rts_rise;
      logic cts_rise;
   } modem_event_s;

   // reads and writes of registers held elsewhere in the channel
   typedef struct packed {
      logic line_status_read;
      logic modem_status_read;
      logic receive_holding_read;
      logic transmit_holding_write;
   } host_access_s;

   function automatic logic [7:0] rx_trigger_lut(input logic [1:0] tbl, input logic [1:0] sel);
      logic [7:0] v;
      v = 8'h01;
      case ({tbl, sel})
         4'h0: v = 8'h01;
         4'h1: v = 8'h04;
         4'h2: v = 8'h08;
         4'h3: v = 8'h0E;
         4'h4: v = 8'h08;
         4'h5: v = 8'h10;
         4'h6: v = 8'h18;
         4'h7: v = 8'h1C;
         4'h8: v = 8'h08;
         4'h9: v = 8'h10;
         4'hA: v = 8'h38;
         4'hB: v = 8'h3C;
         default: v = 8'h01;
      endcase
      return v;
   endfunction : rx_trigger_lut

   function automatic logic [7:0] tx_trigger_lut(input logic [1:0] tbl, input logic [1:0] sel);
      logic [7:0] v;
      v = 8'h01;
      case ({tbl, sel})
         4'h4: v = 8'h10;
         4'h5: v = 8'h08;
         4'h6: v = 8'h18;
         4'h7: v = 8'h1E;
         4'h8: v = 8'h08;
         4'h9: v = 8'h10;
         4'hA: v = 8'h20;
         4'hB: v = 8'h38;
         default: v = 8'h01;
      endcase
      return v;
   endfunction : tx_trigger_lut

endpackage : uart_irq_fifo_pkg

// File: uart_irq_fifo_ctrl.sv
// interrupt enable, prioritised interrupt status and fifo control of one uart channel
// assumes the fifos, receiver, transmitter and modem logic sit on the same clock
// and report levels and one-cycle event pulses through the ports below
//
// Contract
// - rx data interrupt on holding data or trigger
// - tx ready interrupt on empty, also at enable
// - line status interrupt on errored character
// - modem status interrupt on delta bits 0-3
// - upper enables need enhanced bit; reset zero
// - rts and cts rising edges interrupt
// - time-out after four chars plus twelve bits
// - rs485 mode uses transmitter empty
// - status shows highest pending, others queued
// - priority codes for seven sources and none
// - line, rx data, time-out clearing
// - tx ready cleared by status read showing it, or holding write
// - modem and flow interrupts cleared by modem read
// - xoff and special character clearing
// - status bits 5:4 only with enhanced bit
// - bit 0 low when pending; 3:1 code
// - bits 7:6 show fifo enable
// - fifo bits programmed only with enable set
// - flush bits self-clear, reset pointers only
// - dma bit selects ready pin behaviour
// - tx trigger falls below level; enhanced access
// - rx trigger crossing; shared table
// - three fixed trigger tables
// - table 11 uses programmable trigger register
// - data ready on arrival, clear on empty
`timescale 1ns/1ps
module uart_irq_fifo_ctrl
   import uart_irq_fifo_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   output logic [31:0] o_prdata,
   output logic o_pready,
   output logic o_pslverr,
   input wire rx_event_s i_rx_ev,
   input wire modem_event_s i_modem_ev,
   input wire host_access_s i_access,
   input wire logic [7:0] i_rx_level,
   input wire logic [7:0] i_tx_level,
   input wire logic i_tx_shift_empty,
   input wire logic i_bit_tick,
   input wire logic [3:0] i_char_bits,
   output logic o_irq,
   output logic o_fifo_enable,
   output logic o_rx_flush,
   output logic o_tx_flush,
   output logic o_dma_mode,
   output logic [7:0] o_rx_trigger,
   output logic [7:0] o_tx_trigger,
   output logic o_data_ready,
   output logic o_rs485_dir,
   output logic o_rx_ready_n,
   output logic o_tx_ready_n
);

   // ***********************************************************
   // apb decode
   // ***********************************************************
   logic setup;
   logic wr_acc;
   logic rd_acc;
   logic mapped;
   logic ie_wr;
   logic fc_wr;
   logic ef_wr;
   logic ft_wr;
   logic trg_wr;
   logic status_rd;
   logic [7:0] wbyte;

   assign setup = i_psel && !i_penable;
   assign wr_acc = i_psel && i_penable && i_pwrite;
   assign rd_acc = i_psel && i_penable && !i_pwrite;
   assign wbyte = i_pwdata[7:0];
   assign o_pready = 1'b1;

   always_comb
   begin
      mapped = 1'b1;
      if (i_paddr == ADDR_INTERRUPT_ENABLE)
         mapped = 1'b1;
      else if (i_paddr == ADDR_INTERRUPT_STATUS)
         mapped = 1'b1;
      else if (i_paddr == ADDR_FIFO_CONTROL)
         mapped = 1'b1;
      else if (i_paddr == ADDR_ENHANCED_FUNCTION)
         mapped = 1'b1;
      else if (i_paddr == ADDR_FEATURE_CONTROL)
         mapped = 1'b1;
      else if (i_paddr == ADDR_PROGRAMMABLE_TRIGGER)
         mapped = 1'b1;
      else
         mapped = 1'b0;
   end

   assign o_pslverr = i_psel && i_penable && !mapped;
   assign ie_wr = wr_acc && (i_paddr == ADDR_INTERRUPT_ENABLE);
   assign fc_wr = wr_acc && (i_paddr == ADDR_FIFO_CONTROL);
   assign ef_wr = wr_acc && (i_paddr == ADDR_ENHANCED_FUNCTION);
   assign ft_wr = wr_acc && (i_paddr == ADDR_FEATURE_CONTROL);
   assign trg_wr = wr_acc && (i_paddr == ADDR_PROGRAMMABLE_TRIGGER);
   assign status_rd = rd_acc && (i_paddr == ADDR_INTERRUPT_STATUS);

   // ***********************************************************
   // control registers
   // ***********************************************************
   logic [7:0] ie_q;
   logic [7:0] ef_q;
   logic [7:0] ft_q;
   logic [7:0] rx_prog_q;
   logic [7:0] tx_prog_q;
   logic fifo_en_q;
   logic dma_q;
   logic [1:0] rx_sel_q;
   logic [1:0] tx_sel_q;
   logic rx_flush_q;
   logic tx_flush_q;
   logic enhanced;

   assign enhanced = ef_q[EF_ENHANCED];

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         ie_q <= RESET_BYTE;
      else if (ie_wr)
      begin
         // upper enables hold their value unless the enhanced bit is set
         if (enhanced)
            ie_q <= wbyte;
         else
            ie_q <= (ie_q & IE_UPPER_MASK) | (wbyte & ~IE_UPPER_MASK);
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         ef_q <= RESET_BYTE;
         ft_q <= RESET_BYTE;
      end
      else
      begin
         if (ef_wr)
            ef_q <= wbyte;
         if (ft_wr)
            ft_q <= wbyte;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         rx_prog_q <= LEVEL_ZERO;
         tx_prog_q <= LEVEL_ZERO;
      end
      else if (trg_wr)
      begin
         if (ft_q[FT_TRG_TARGET])
            tx_prog_q <= wbyte;
         else
            rx_prog_q <= wbyte;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         fifo_en_q <= 1'b0;
         dma_q <= 1'b0;
         rx_sel_q <= 2'h0;
         tx_sel_q <= 2'h0;
      end
      else if (fc_wr)
      begin
         fifo_en_q <= wbyte[FC_ENABLE];
         // the other bits are ignored unless the same write enables the fifos
         if (wbyte[FC_ENABLE])
         begin
            dma_q <= wbyte[FC_DMA];
            rx_sel_q <= wbyte[7:6];
            if (enhanced)
               tx_sel_q <= wbyte[5:4];
         end
      end
   end

   // flush strobes last one cycle and never read back
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         rx_flush_q <= 1'b0;
         tx_flush_q <= 1'b0;
      end
      else
      begin
         rx_flush_q <= fc_wr && wbyte[FC_ENABLE] && wbyte[FC_RX_FLUSH];
         tx_flush_q <= fc_wr && wbyte[FC_ENABLE] && wbyte[FC_TX_FLUSH];
      end
   end

   // ***********************************************************
   // trigger levels
   // ***********************************************************
   logic [1:0] table_sel;
   logic [7:0] rx_trig;
   logic [7:0] tx_trig;

   assign table_sel = ft_q[5:4];

   always_comb
   begin
      if (table_sel == TABLE_PROG)
      begin
         rx_trig = rx_prog_q;
         tx_trig = tx_prog_q;
      end
      else
      begin
         rx_trig = rx_trigger_lut(table_sel, rx_sel_q);
         tx_trig = tx_trigger_lut(table_sel, tx_sel_q);
      end
   end

   // ***********************************************************
   // interrupt sources
   // ***********************************************************
   logic line_q;
   logic timeout_q;
   logic tx_int_q;
   logic modem_q;
   logic xoff_q;
   logic special_q;
   logic rts_q;
   logic cts_q;
   logic tx_cond_q;
   logic tx_ie_q;
   logic rx_data_lvl;
   logic tx_cond;
   logic tx_set;
   logic tx_reported;
   irq_code_e code;

   // level source: no flag, clears itself as reads drain the fifo
   assign rx_data_lvl = ie_q[IE_RX_DATA] &&
      (fifo_en_q ? (i_rx_level >= rx_trig) : (i_rx_level != LEVEL_ZERO));

   always_comb
   begin
      if (ft_q[FT_RS485])
         tx_cond = i_tx_shift_empty;
      else if (fifo_en_q)
         tx_cond = (i_tx_level < tx_trig) || (i_tx_level == LEVEL_ZERO);
      else
         tx_cond = (i_tx_level == LEVEL_ZERO);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         tx_cond_q <= 1'b1;
         tx_ie_q <= 1'b0;
      end
      else
      begin
         tx_cond_q <= tx_cond;
         tx_ie_q <= ie_q[IE_TX_READY];
      end
   end

   // new empty condition, or enable raised while already empty
   assign tx_set = ie_q[IE_TX_READY] && tx_cond && (!tx_cond_q || !tx_ie_q);
   assign tx_reported = status_rd && (code == CODE_TX_READY);

   // in every flag below the set term is tested first so that it wins
   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         line_q <= 1'b0;
      else if (i_rx_ev.char_in && (i_rx_ev.line_err != 4'h0))
         line_q <= 1'b1;
      else if (i_access.line_status_read)
         line_q <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         tx_int_q <= 1'b0;
      else if (tx_set)
         tx_int_q <= 1'b1;
      else if (tx_reported || i_access.transmit_holding_write)
         tx_int_q <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         modem_q <= 1'b0;
      else if (i_modem_ev.msr_delta != 4'h0)
         modem_q <= 1'b1;
      else if (i_access.modem_status_read)
         modem_q <= 1'b0;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         rts_q <= 1'b0;
         cts_q <= 1'b0;
      end
      else
      begin
         if (i_modem_ev.rts_rise && ef_q[EF_AUTO_RTS])
            rts_q <= 1'b1;
         else if (i_access.modem_status_read)
            rts_q <= 1'b0;
         if (i_modem_ev.cts_rise && ef_q[EF_AUTO_CTS])
            cts_q <= 1'b1;
         else if (i_access.modem_status_read)
            cts_q <= 1'b0;
      end
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         xoff_q <= 1'b0;
         special_q <= 1'b0;
      end
      else
      begin
         if (i_rx_ev.xoff_match)
            xoff_q <= 1'b1;
         else if (status_rd || i_rx_ev.xon_match)
            xoff_q <= 1'b0;
         if (i_rx_ev.special_match)
            special_q <= 1'b1;
         else if (status_rd || i_rx_ev.char_in)
            special_q <= 1'b0;
      end
   end

   // ***********************************************************
   // receive time-out timer, counted in bit times
   // ***********************************************************
   logic [7:0] bit_cnt_q;
   logic [7:0] timeout_limit;
   logic timer_restart;

   assign timeout_limit = 8'(TIMEOUT_CHARS * {4'h0, i_char_bits}) + TIMEOUT_EXTRA_BITS;
   assign timer_restart = i_rx_ev.char_in || i_access.receive_holding_read ||
      (i_rx_level == LEVEL_ZERO) || !fifo_en_q;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         bit_cnt_q <= LEVEL_ZERO;
      else if (timer_restart)
         bit_cnt_q <= LEVEL_ZERO;
      else if (i_bit_tick && (bit_cnt_q < timeout_limit))
         bit_cnt_q <= bit_cnt_q + 8'h01;
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         timeout_q <= 1'b0;
      else if (!timer_restart && (bit_cnt_q == timeout_limit))
         timeout_q <= 1'b1;
      else if (i_access.receive_holding_read)
         timeout_q <= 1'b0;
   end

   // ***********************************************************
   // priority encoder and status
   // ***********************************************************
   logic [7:0] status_byte;

   // lower sources stay flagged until their own clear; only the top one shows
   always_comb
   begin
      if (line_q && ie_q[IE_LINE])
         code = CODE_LINE;
      else if (timeout_q && ie_q[IE_RX_DATA])
         code = CODE_TIMEOUT;
      else if (rx_data_lvl)
         code = CODE_RX_DATA;
      else if (tx_int_q && ie_q[IE_TX_READY])
         code = CODE_TX_READY;
      else if (modem_q && ie_q[IE_MODEM])
         code = CODE_MODEM;
      else if (enhanced && (xoff_q || special_q) && ie_q[IE_XOFF])
         code = CODE_XOFF;
      else if (enhanced && ((rts_q && ie_q[IE_RTS]) || (cts_q && ie_q[IE_CTS])))
         code = CODE_FLOW;
      else
         code = CODE_NONE;
   end

   assign status_byte = {fifo_en_q, fifo_en_q, code};

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         o_prdata <= 32'h0000_0000;
      else if (setup && !i_pwrite)
      begin
         if (i_paddr == ADDR_INTERRUPT_ENABLE)
            o_prdata <= {24'h00_0000, ie_q};
         else if (i_paddr == ADDR_INTERRUPT_STATUS)
            o_prdata <= {24'h00_0000, status_byte};
         else if (i_paddr == ADDR_ENHANCED_FUNCTION)
            o_prdata <= {24'h00_0000, ef_q};
         else if (i_paddr == ADDR_FEATURE_CONTROL)
            o_prdata <= {24'h00_0000, ft_q};
         else
            o_prdata <= 32'h0000_0000;
      end
   end

   // ***********************************************************
   // outputs
   // ***********************************************************
   logic irq_q;
   logic rx_rdy_n_q;
   logic tx_rdy_n_q;

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
         irq_q <= 1'b0;
      else
         irq_q <= (code != CODE_NONE);
   end

   always_ff @(posedge i_clk)
   begin
      if (i_srst)
      begin
         rx_rdy_n_q <= 1'b1;
         tx_rdy_n_q <= 1'b0;
      end
      else if (dma_q)
      begin
         rx_rdy_n_q <= !((i_rx_level >= rx_trig) || timeout_q);
         tx_rdy_n_q <= !(i_tx_level < FIFO_DEPTH);
      end
      else
      begin
         rx_rdy_n_q <= (i_rx_level == LEVEL_ZERO);
         tx_rdy_n_q <= (i_tx_level != LEVEL_ZERO);
      end
   end

   assign o_irq = irq_q;
   assign o_fifo_enable = fifo_en_q;
   assign o_rx_flush = rx_flush_q;
   assign o_tx_flush = tx_flush_q;
   assign o_dma_mode = dma_q;
   assign o_rx_trigger = rx_trig;
   assign o_tx_trigger = tx_trig;
   assign o_data_ready = (i_rx_level != LEVEL_ZERO);
   assign o_rs485_dir = ft_q[FT_RS485];
   assign o_rx_ready_n = rx_rdy_n_q;
   assign o_tx_ready_n = tx_rdy_n_q;

endmodule : uart_irq_fifo_ctrl

// File: uart_irq_fifo_ctrl_assertions.sv
// checker for the channel interrupt and fifo control block
// assumes it is bound to the block and sees only its ports
`timescale 1ns/1ps
module uart_irq_fifo_ctrl_assertions
   import uart_irq_fifo_pkg::*;
(
   input wire logic i_clk,
   input wire logic i_srst,
   input wire logic i_psel,
   input wire logic i_penable,
   input wire logic i_pwrite,
   input wire logic [7:0] i_paddr,
   input wire logic [31:0] i_pwdata,
   input wire logic [31:0] o_prdata,
   input wire logic [7:0] i_rx_level,
   input wire logic o_fifo_enable,
   input wire logic o_rx_flush,
   input wire logic o_tx_flush,
   input wire logic o_dma_mode,
   input wire logic o_data_ready,
   input wire logic o_rx_ready_n
);
   // ************************************************
   // bus phases
   // ************************************************
   default clocking cb @(posedge i_clk);
   endclocking
   default disable iff (i_srst);
   sequence s_fc_wr;
      i_psel && i_penable && i_pwrite && i_paddr == ADDR_FIFO_CONTROL;
   endsequence
   sequence s_st_rd;
      i_psel && i_penable && !i_pwrite && i_paddr == ADDR_INTERRUPT_STATUS;
   endsequence
   // ************************************************
   // properties
   // ************************************************
   a_status_fifo_bits: assert property (s_st_rd |-> o_prdata[7:6] == {2{o_fifo_enable}})
      else $error("status fifo bits disagree with enable");
   a_status_none_code: assert property (s_st_rd ##0 o_prdata[0] |-> o_prdata[5:1] == 5'h00)
      else $error("no pending but source bits set");
   a_rx_flush_cause: assert property (o_rx_flush |-> $past(i_psel && i_penable && i_pwrite
      && i_paddr == ADDR_FIFO_CONTROL && i_pwdata[0] && i_pwdata[1]))
      else $error("rx flush without enabled flush write");
   a_tx_flush_cause: assert property (o_tx_flush |-> $past(i_psel && i_penable && i_pwrite
      && i_paddr == ADDR_FIFO_CONTROL && i_pwdata[0] && i_pwdata[2]))
      else $error("tx flush without enabled flush write");
   a_fifo_enable_follow: assert property (s_fc_wr |=> o_fifo_enable == $past(i_pwdata[0]))
      else $error("fifo enable not taken from write");
   a_dma_gated: assert property (s_fc_wr ##0 !i_pwdata[0] |=> $stable(o_dma_mode))
      else $error("dma bit changed without enable bit");
   a_dma_taken: assert property (s_fc_wr ##0 i_pwdata[0] |=> o_dma_mode == $past(i_pwdata[3]))
      else $error("dma bit not taken from write");
   a_data_ready_level: assert property (o_data_ready == (i_rx_level != LEVEL_ZERO))
      else $error("data ready disagrees with level");
   a_rx_pin_normal: assert property (!o_dma_mode && !$past(o_dma_mode) && !$past(i_srst)
      |-> o_rx_ready_n == ($past(i_rx_level) == LEVEL_ZERO))
      else $error("rx ready pin wrong in normal mode");
endmodule : uart_irq_fifo_ctrl_assertions

// File: host_apb_model.sv
// host processor model: apb master issuing single transfers
// assumes tasks are called right after a rising clock edge
`timescale 1ns/1ps
module host_apb_model
(
   input wire logic i_clk,
   input wire logic i_pready,
   input wire logic [31:0] i_prdata,
   input wire logic i_pslverr,
   output logic o_psel,
   output logic o_penable,
   output logic o_pwrite,
   output logic [7:0] o_paddr,
   output logic [31:0] o_pwdata
);
   initial
   begin
      o_psel = 1'b0;
      o_penable = 1'b0;
      o_pwrite = 1'b0;
      o_paddr = 8'hFF;
      o_pwdata = 32'h0;
   end
   // ends one edge after release so a following call never reassigns psel in the same step
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] r, output logic e, output bit hung);
      r = 32'h0;
      e = 1'b0;
      hung = 1'b1;
      o_psel <= 1'b1;
      o_penable <= 1'b0;
      o_pwrite <= w;
      o_paddr <= a;
      o_pwdata <= d;
      @(posedge i_clk);
      o_penable <= 1'b1;
      for (int n = 0; n < 16 && hung; n++)
      begin
         @(posedge i_clk);
         if (i_pready === 1'b1)
         begin
            r = i_prdata;
            e = i_pslverr;
            hung = 1'b0;
         end
      end
      o_psel <= 1'b0;
      o_penable <= 1'b0;
      o_paddr <= ~a;
      o_pwdata <= ~d;
      @(posedge i_clk);
   endtask : xfer
endmodule : host_apb_model

// File: tb_uart_irq_fifo_ctrl.sv
// self-checking bench for the channel interrupt and fifo control block
// assumes the host model drives apb and the bench pulses channel events
`timescale 1ns/1ps
module tb_uart_irq_fifo_ctrl;
   import uart_irq_fifo_pkg::*;
   logic i_clk = 1'b0;
   logic i_srst = 1'b1;
   logic i_psel, i_penable, i_pwrite, o_pready, o_pslverr, o_irq, o_fifo_enable;
   logic o_rx_flush, o_tx_flush, o_dma_mode, o_data_ready, o_rs485_dir;
   logic o_rx_ready_n, o_tx_ready_n;
   logic [7:0] i_paddr, o_rx_trigger, o_tx_trigger;
   logic [31:0] i_pwdata, o_prdata;
   logic [31:0] seed = 32'h5D86;
   rx_event_s i_rx_ev = '0;
   modem_event_s i_modem_ev = '0;
   host_access_s i_access = '0;
   logic [7:0] i_rx_level = 8'h00;
   logic [7:0] i_tx_level = 8'h01;
   logic i_tx_shift_empty = 1'b1;
   logic i_bit_tick = 1'b0;
   logic [3:0] i_char_bits = 4'hA;
   logic [7:0] rxt [12] = '{8'h01, 8'h04, 8'h08, 8'h0E, 8'h08, 8'h10, 8'h18, 8'h1C,
      8'h08, 8'h10, 8'h38, 8'h3C};
   logic [7:0] txt [12] = '{8'h01, 8'h01, 8'h01, 8'h01, 8'h10, 8'h08, 8'h18, 8'h1E,
      8'h08, 8'h10, 8'h20, 8'h38};
   int fail_count = 0;
   int n_checks = 0;
   int ln = 0, rd_p = 0, tr = 0, ms = 0, xf = 0, fl = 0, fen = 0;
   logic [31:0] r;
   logic e;
   always #25 i_clk = ~i_clk;
   uart_irq_fifo_ctrl u_dut (.i_clk, .i_srst, .i_psel, .i_penable, .i_pwrite, .i_paddr,
      .i_pwdata, .o_prdata, .o_pready, .o_pslverr, .i_rx_ev, .i_modem_ev, .i_access,
      .i_rx_level, .i_tx_level, .i_tx_shift_empty, .i_bit_tick, .i_char_bits, .o_irq,
      .o_fifo_enable, .o_rx_flush, .o_tx_flush, .o_dma_mode, .o_rx_trigger, .o_tx_trigger,
      .o_data_ready, .o_rs485_dir, .o_rx_ready_n, .o_tx_ready_n);
   host_apb_model u_host (.i_clk, .i_pready(o_pready), .i_prdata(o_prdata),
      .i_pslverr(o_pslverr), .o_psel(i_psel), .o_penable(i_penable), .o_pwrite(i_pwrite),
      .o_paddr(i_paddr), .o_pwdata(i_pwdata));
   // ************************************************
   // model and helpers
   // ************************************************
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic [7:0] exp_isr();
      logic [5:0] c;
      c = ln ? 6'h06 : rd_p ? 6'h04 : tr ? 6'h02 : ms ? 6'h00 : xf ? 6'h10 : fl ? 6'h20 : 6'h01;
      return {fen ? 2'h3 : 2'h0, c};
   endfunction : exp_isr
   task automatic stop_test();
      $display("checks %0d errors %0d", n_checks, fail_count);
      if (fail_count == 0 && n_checks > 0)
         $display("Testbench passed");
      else
         $display("Testbench failed");
      $finish;
   endtask : stop_test
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      n_checks++;
      if (seen !== exp)
      begin
         fail_count++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : chk
   task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d,
      output logic [31:0] q, output logic err);
      bit h;
      u_host.xfer(w, a, d, q, err, h);
      if (h)
      begin
         fail_count++;
         stop_test();
      end
   endtask : bus
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      logic err;
      bus(1'b1, a, d, q, err);
   endtask : wr
   // a status read clears xoff and the shown tx source
   task automatic rd_isr();
      logic [31:0] q;
      logic err;
      logic [7:0] x;
      x = exp_isr();
      bus(1'b0, ADDR_INTERRUPT_STATUS, 32'h0, q, err);
      chk(q, {24'h0, x});
      if (x[5:0] == 6'h02)
         tr = 0;
      xf = 0;
   endtask : rd_isr
   task automatic ev(input rx_event_s rv, input modem_event_s mv, input host_access_s av);
      i_rx_ev <= rv;
      i_modem_ev <= mv;
      i_access <= av;
      @(posedge i_clk);
      i_rx_ev <= '0;
      i_modem_ev <= '0;
      i_access <= '0;
      @(posedge i_clk);
   endtask : ev
   task automatic lv(input logic [7:0] rx, input logic [7:0] tx);
      i_rx_level <= rx;
      i_tx_level <= tx;
      repeat (2) @(posedge i_clk);
   endtask : lv
   // ************************************************
   // main sequence
   // ************************************************
   initial
   begin
      repeat (2) @(posedge i_clk);
      i_srst <= 1'b0;
      bus(1'b0, ADDR_INTERRUPT_ENABLE, 32'h0, r, e);
      chk(r, 32'h0);
      rd_isr();
      bus(1'b0, 8'h40, 32'h0, r, e);
      chk(r, 32'h0);
      chk({31'h0, e}, 32'h1);
      wr(ADDR_INTERRUPT_ENABLE, 32'hFF);
      bus(1'b0, ADDR_INTERRUPT_ENABLE, 32'h0, r, e);
      chk(r, 32'h0F);
      wr(ADDR_INTERRUPT_ENABLE, 32'h0);
      wr(ADDR_ENHANCED_FUNCTION, 32'hD0);
      wr(ADDR_FIFO_CONTROL, 32'h0E);
      chk({o_fifo_enable, o_dma_mode}, 2'h0);
      wr(ADDR_FIFO_CONTROL, 32'h0F);
      chk({o_fifo_enable, o_dma_mode}, 2'h3);
      fen = 1;
      rd_isr();
      for (int t = 0; t < 3; t++)
      begin
         for (int s = 0; s < 4; s++)
         begin
            wr(ADDR_FEATURE_CONTROL, 32'(t) << 4);
            wr(ADDR_FIFO_CONTROL, {24'h0, 2'(s), 2'(s), 4'h1});
            chk(o_rx_trigger, rxt[t * 4 + s]);
            chk(o_tx_trigger, txt[t * 4 + s]);
         end
      end
      seed = lfsr(seed);
      wr(ADDR_FEATURE_CONTROL, 32'h38);
      chk(o_rs485_dir, 1'b1);
      wr(ADDR_PROGRAMMABLE_TRIGGER, {25'h0, seed[6:0]});
      chk(o_rx_trigger, {1'b0, seed[6:0]});
      seed = lfsr(seed);
      wr(ADDR_FEATURE_CONTROL, 32'hB0);
      wr(ADDR_PROGRAMMABLE_TRIGGER, {25'h0, seed[6:0]});
      chk(o_tx_trigger, {1'b0, seed[6:0]});
      wr(ADDR_FIFO_CONTROL, 32'h0);
      fen = 0;
      wr(ADDR_INTERRUPT_ENABLE, 32'hFD);
      lv(8'h01, 8'h01);
      rd_p = 1;
      rd_isr();
      ev(8'h88, 6'h04, 4'h0);
      ln = 1;
      ms = 1;
      rd_isr();
      chk(o_irq, 1'b1);
      ev(8'h00, 6'h00, 4'h8);
      ln = 0;
      rd_isr();
      lv(8'h00, 8'h01);
      rd_p = 0;
      rd_isr();
      lv(8'h00, 8'h00);
      wr(ADDR_INTERRUPT_ENABLE, 32'hFF);
      tr = 1;
      rd_isr();
      rd_isr();
      ev(8'h00, 6'h00, 4'h4);
      ms = 0;
      rd_isr();
      chk(o_irq, 1'b0);
      ev(8'h04, 6'h00, 4'h0);
      xf = 1;
      rd_isr();
      rd_isr();
      ev(8'h00, 6'h01, 4'h0);
      fl = 1;
      rd_isr();
      ev(8'h00, 6'h00, 4'h4);
      fl = 0;
      rd_isr();
      lv(8'h00, 8'h01);
      lv(8'h00, 8'h00);
      ev(8'h00, 6'h00, 4'h1);
      rd_isr();
      stop_test();
   end
endmodule : tb_uart_irq_fifo_ctrl

bind uart_irq_fifo_ctrl uart_irq_fifo_ctrl_assertions u_chk (.i_clk, .i_srst, .i_psel,
   .i_penable, .i_pwrite, .i_paddr, .i_pwdata, .o_prdata, .i_rx_level, .o_fifo_enable,
   .o_rx_flush, .o_tx_flush, .o_dma_mode, .o_data_ready, .o_rx_ready_n);
